// *** pwm_chan_defs.vh ***
/*
 * pwm_chan_defs.vh: register offsets, field positions, reset values and
 * encodings of the standard pwm channel.
 * assumes: included by bare name by the channel top module and the bench top.
 */
`ifndef PWM_CHAN_DEFS_VH
`define PWM_CHAN_DEFS_VH

// register offsets (byte-wide registers, 4-bit address)
`define A_CTRL        4'h0
`define A_DUTY_MSB    4'h1
`define A_DUTY_SHADOW 4'h2
`define A_TSEL        4'h3
`define A_PERIOD0     4'h4
`define A_PERIOD1     4'h5
`define A_PERIOD2     4'h6
`define A_TCTRL0      4'h7
`define A_TCTRL1      4'h8
`define A_TCTRL2      4'h9
`define A_TCOUNT0     4'hA
`define A_TCOUNT1     4'hB
`define A_TCOUNT2     4'hC
`define A_FLAGS       4'hD
`define A_PINDIR      4'hE

// channel control fields
`define CTRL_DLSB_HI  5
`define CTRL_DLSB_LO  4
`define CTRL_MODE_HI  3
`define CTRL_MODE_LO  0
`define MODE_PWM_HI   2'h3

// timer control fields
`define TC_RUN        2
`define TC_PS_HI      1
`define TC_PS_LO      0
`define PS_DIV1       2'h0
`define PS_DIV4       2'h1

// timer select encodings
`define TSEL_T0       2'h0
`define TSEL_T1       2'h1
`define TSEL_T2       2'h2

// reset values
`define RST_BYTE      8'h00
`define RST_PERIOD    8'hFF
`define RST_PINDIR    1'b1
`define RST_DUTY10    10'h000

`endif

// *** pwm_load_model.sv ***
/* pwm_load_model.sv: load on the pwm pin, pulled down, timing its pulses.
   assumes: shares clk with the channel; lengths settle after two rises. */
`timescale 1ns/1ps
module pwm_load_model (
    input  wire  clk,
    input  wire  pin_out,
    input  wire  pin_oe,
    output logic pad,
    output int   hi_len,
    output int   per_len
);
    int   run = 0;
    logic prev = 1'b0;
    // released pin sinks to the pull-down, never the last level
    assign pad = pin_oe ? pin_out : 1'b0;
    // clocks since the last rise, latched on each pad edge
    always @(posedge clk) begin
        prev <= pad;
        run  <= (pad && !prev) ? 1 : run + 1;
        if (pad && !prev) per_len <= run;
        if (!pad && prev) hi_len <= run;
    end
endmodule // pwm_load_model

// *** standard_pwm_channel.v ***
/*
 * standard_pwm_channel.v: ten-bit standard pwm channel with three 8-bit
 * period timers, double-buffered duty and a byte register port.
 * assumes: one clock, synchronous active-high reset, sleep_req is a level
 * synchronous to clk; the pad combines pin_out and pin_oe.
 */
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pwm_chan_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module standard_pwm_channel #(
    parameter NUM_TIMERS = 3
) (
    input  wire       clk,
    input  wire       rst,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       sleep_req,
    output reg        pin_out,
    output reg        pin_oe
);

    // per-timer state, flattened 8-bit slots
    reg  [8*NUM_TIMERS-1:0] period_q;
    reg  [8*NUM_TIMERS-1:0] tctrl_q;
    reg  [8*NUM_TIMERS-1:0] tcount_q;
    reg  [2*NUM_TIMERS-1:0] quarter_q;   // 2-bit quarter-cycle phase
    reg  [4*NUM_TIMERS-1:0] psc_q;       // prescaler up to 1:16
    reg  [NUM_TIMERS-1:0]   match_flag_q;
    wire [NUM_TIMERS-1:0]   tick;        // timer increment strobe
    wire [NUM_TIMERS-1:0]   rollover;    // increment while count equals period
    wire [2*NUM_TIMERS-1:0] lowbits;

    reg  [7:0] ctrl_q;
    reg  [7:0] duty_msb_q;
    reg  [7:0] duty_shadow_q;
    reg  [1:0] duty_latch_q;
    reg  [1:0] tsel_q;
    reg        pin_dir_q;
    reg        pwm_level_q;

    // prescale factor minus one as a 4-bit terminal count
    function [3:0] ps_last;
        input [1:0] ps;
        begin
            case (ps)
                `PS_DIV1: ps_last = 4'h0;
                `PS_DIV4: ps_last = 4'h3;
                default:  ps_last = 4'hF;
            endcase
        end
    endfunction

    // register write decode, used for several registers
    function is_wr;
        input [3:0] a;
        input [3:0] target;
        begin
            is_wr = reg_wr && (a == target);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // three period timers; postscaler not modelled since it never shapes pwm
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g = g + 1) begin : g_tmr
            wire [7:0] per   = period_q[8*g +: 8];
            wire [7:0] cnt   = tcount_q[8*g +: 8];
            wire [1:0] ps    = tctrl_q[8*g+`TC_PS_HI -: 2];
            wire       run   = tctrl_q[8*g+`TC_RUN] && !sleep_req;
            wire [1:0] qtr   = quarter_q[2*g +: 2];
            wire [3:0] pc    = psc_q[4*g +: 4];
            wire       qwrap = (qtr == 2'h3);
            // register index of this timer's slots
            localparam integer PER_IDX = `A_PERIOD0 + g;
            localparam integer TC_IDX  = `A_TCTRL0 + g;
            localparam integer CNT_IDX = `A_TCOUNT0 + g;
            // one increment per 4 clocks times prescale
            assign tick[g]     = run && qwrap && (pc == ps_last(ps));
            assign rollover[g] = tick[g] && (cnt == per);
            // 1:1 uses clock phase, else the prescaler bits that step once
            // per prescaled clock, so each time base step is one prescale
            assign lowbits[2*g +: 2] = (ps == `PS_DIV1) ? qtr :
                                       ((ps == `PS_DIV4) ? pc[1:0] : pc[3:2]);

            always @(posedge clk) begin
                if (rst) begin
                    quarter_q[2*g +: 2] <= 2'h0;
                    psc_q[4*g +: 4]     <= 4'h0;
                    tcount_q[8*g +: 8]  <= `RST_BYTE;
                    match_flag_q[g]     <= 1'b0;
                end else begin
                    if (run) begin
                        quarter_q[2*g +: 2] <= qtr + 2'h1;
                        if (qwrap)
                            psc_q[4*g +: 4] <= (pc == ps_last(ps)) ? 4'h0 : pc + 4'h1;
                    end
                    // software count write loses to hardware increment
                    if (rollover[g])
                        tcount_q[8*g +: 8] <= `RST_BYTE;
                    else if (tick[g])
                        tcount_q[8*g +: 8] <= cnt + 8'h01;
                    else if (is_wr(reg_addr, CNT_IDX[3:0]))
                        tcount_q[8*g +: 8] <= reg_wdata;
                    // set wins over software clear
                    if (rollover[g])
                        match_flag_q[g] <= 1'b1;
                    else if (is_wr(reg_addr, `A_FLAGS) && !reg_wdata[g])
                        match_flag_q[g] <= 1'b0;
                end
            end

            always @(posedge clk) begin
                if (rst) begin
                    period_q[8*g +: 8] <= `RST_PERIOD;
                    tctrl_q[8*g +: 8]  <= `RST_BYTE;
                end else begin
                    if (is_wr(reg_addr, PER_IDX[3:0]))
                        period_q[8*g +: 8] <= reg_wdata;
                    if (is_wr(reg_addr, TC_IDX[3:0]))
                        tctrl_q[8*g +: 8] <= reg_wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // selected time base; reserved select freezes the channel
    reg        sel_valid;
    reg        sel_roll;
    reg        sel_tick;
    reg  [7:0] sel_cnt;
    reg  [1:0] sel_low;
    reg  [7:0] sel_per;
    always @* begin
        sel_valid = 1'b1;
        sel_roll  = 1'b0;
        sel_tick  = 1'b0;
        sel_cnt   = 8'h00;
        sel_low   = 2'h0;
        sel_per   = 8'h00;
        case (tsel_q)
            `TSEL_T0, `TSEL_T1, `TSEL_T2: begin
                sel_roll = rollover[tsel_q];
                sel_tick = tick[tsel_q];
                sel_cnt  = tcount_q[8*tsel_q +: 8];
                sel_low  = lowbits[2*tsel_q +: 2];
                sel_per  = period_q[8*tsel_q +: 8];
            end
            default: sel_valid = 1'b0;
        endcase
    end

    wire       pwm_mode  = (ctrl_q[`CTRL_MODE_HI -: 2] == `MODE_PWM_HI);
    wire [9:0] duty_next = {duty_msb_q, ctrl_q[`CTRL_DLSB_HI:`CTRL_DLSB_LO]};
    wire [9:0] duty_live = {duty_shadow_q, duty_latch_q};
    wire [9:0] time_base = {sel_cnt, sel_low};
    // a match beyond the period never occurs, so pin stays set
    wire       duty_hit  = (time_base == duty_live);
    // match drops the pin at the same edge as the level, so high time is exact
    wire       clear_now = pwm_mode && sel_valid && duty_hit;

    ////////////////////////////////////////////////////////////////////////////
    // pwm waveform and duty double buffer
    always @(posedge clk) begin
        if (rst) begin
            duty_shadow_q <= `RST_BYTE;
            duty_latch_q  <= 2'h0;
            pwm_level_q   <= 1'b0;
        end else if (pwm_mode && sel_valid && !sleep_req) begin
            if (sel_roll) begin
                duty_shadow_q <= duty_next[9:2];
                duty_latch_q  <= duty_next[1:0];
                pwm_level_q   <= (duty_next != `RST_DUTY10);
            end else if (duty_hit) begin
                pwm_level_q   <= 1'b0;
            end
        end else if (!pwm_mode) begin
            pwm_level_q   <= 1'b0;
            if (is_wr(reg_addr, `A_DUTY_SHADOW))
                duty_shadow_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software-owned registers
    always @(posedge clk) begin
        if (rst) begin
            ctrl_q     <= `RST_BYTE;
            duty_msb_q <= `RST_BYTE;
            tsel_q     <= `TSEL_T0;
            pin_dir_q  <= `RST_PINDIR;
        end else begin
            if (is_wr(reg_addr, `A_CTRL))
                ctrl_q <= reg_wdata;
            if (is_wr(reg_addr, `A_DUTY_MSB))
                duty_msb_q <= reg_wdata;
            if (is_wr(reg_addr, `A_TSEL))
                tsel_q <= reg_wdata[1:0];
            if (is_wr(reg_addr, `A_PINDIR))
                pin_dir_q <= reg_wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive: registered; held during sleep
    always @(posedge clk) begin
        if (rst) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else if (!sleep_req) begin
            pin_out <= pwm_level_q && !clear_now;
            // control all zero releases pin; direction bit set blocks
            pin_oe  <= (ctrl_q != `RST_BYTE) && pwm_mode && !pin_dir_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe; unmapped reads zero
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= `RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `A_CTRL:        reg_rdata <= ctrl_q;
                `A_DUTY_MSB:    reg_rdata <= duty_msb_q;
                `A_DUTY_SHADOW: reg_rdata <= duty_shadow_q;
                `A_TSEL:        reg_rdata <= {6'h00, tsel_q};
                `A_PERIOD0:     reg_rdata <= period_q[7:0];
                `A_PERIOD1:     reg_rdata <= period_q[15:8];
                `A_PERIOD2:     reg_rdata <= period_q[23:16];
                `A_TCTRL0:      reg_rdata <= tctrl_q[7:0];
                `A_TCTRL1:      reg_rdata <= tctrl_q[15:8];
                `A_TCTRL2:      reg_rdata <= tctrl_q[23:16];
                `A_TCOUNT0:     reg_rdata <= tcount_q[7:0];
                `A_TCOUNT1:     reg_rdata <= tcount_q[15:8];
                `A_TCOUNT2:     reg_rdata <= tcount_q[23:16];
                `A_FLAGS:       reg_rdata <= {5'h00, match_flag_q};
                `A_PINDIR:      reg_rdata <= {7'h00, pin_dir_q};
                default:        reg_rdata <= `RST_BYTE;
            endcase
        end else begin
            reg_rdata <= `RST_BYTE;
        end
    end

endmodule // standard_pwm_channel

// *** standard_pwm_channel_monitor.sv ***
/* standard_pwm_channel_monitor.sv: port assertions of the pwm channel.
   assumes: bound to standard_pwm_channel, one clock, rst sync high. */
`timescale 1ns/1ps
module standard_pwm_channel_monitor (
    input wire       clk,
    input wire       rst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       sleep_req,
    input wire       pin_out,
    input wire       pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // bus answers only in the cycle after a read
    property p_rd_only;
        reg_rdata != 8'h00 |-> $past(reg_rd);
    endproperty
    a_rd_only: assert property (p_rd_only) else $error("stray read data");
    property p_rd_once;
        reg_rd ##1 !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("read data held");
    property p_unmapped;
        reg_rd && reg_addr == 4'hF |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    // reset must win even though the rest ignore it
    property p_rst_quiet;
        disable iff (1'b0) rst |=> !pin_oe && !pin_out;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("pin after reset");
    property p_ctrl_clr;
        reg_wr && reg_addr == 4'h0 && reg_wdata == 8'h00 |-> ##2 !pin_oe;
    endproperty
    a_ctrl_clr: assert property (p_ctrl_clr) else $error("pin kept");
    property p_dir_in;
        reg_wr && reg_addr == 4'hE && reg_wdata[0] |-> ##2 !pin_oe;
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("driver kept");
    // enable moves only through register writes
    property p_oe_cause;
        $changed(pin_oe) |-> $past(reg_wr) || $past(reg_wr, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("enable moved");
    property p_sleep;
        sleep_req [*2] |=> $stable(pin_out) && $stable(pin_oe);
    endproperty
    a_sleep: assert property (p_sleep) else $error("pin moved asleep");
endmodule // standard_pwm_channel_monitor
bind standard_pwm_channel standard_pwm_channel_monitor u_mon (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_req(sleep_req), .pin_out(pin_out), .pin_oe(pin_oe));

// *** standard_pwm_channel_tb_top.sv ***
/* standard_pwm_channel_tb_top.sv: self-checking bench of the pwm channel.
   assumes: load model and bound monitor compiled before it. */
`timescale 1ns/1ps
`include "pwm_chan_defs.vh"
module standard_pwm_channel_tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       sleep_req = 1'b0;
    logic [7:0] reg_rdata, v;
    logic       pin_out, pin_oe, pad;
    int         hi_len, per_len, p, d, ps, t;
    int         n_mismatch = 0;
    int         checked = 0;
    int         seed = 75;
    // 10 ns clock, channel and its load
    always #5 clk = ~clk;
    standard_pwm_channel dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_req(sleep_req), .pin_out(pin_out), .pin_oe(pin_oe));
    pwm_load_model load (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad),
        .hi_len(hi_len), .per_len(per_len));
////////////////////////////////////////////////////////////
    function automatic int psf(input int c);
        return (c == 0) ? 1 : ((c == 1) ? 4 : 16);
    endfunction
    function automatic logic [7:0] rst_val(input int a);
        return (a >= 4 && a <= 6) ? 8'hFF : ((a == 14) ? 8'h01 : 8'h00);
    endfunction
    task automatic end_of_test;
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // every check is counted, misses reported at once
    task automatic cmp_byte(input string w, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask
    task automatic cmp_len(input string w, input int e, input int g);
        checked++;
        if (g != e) begin
            n_mismatch++;
            $display("unexpected %s: expected %0d seen %0d", w, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] dat);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= dat;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    // read data are taken mid-cycle, well after they launch
    task automatic rd(input logic [3:0] a, output logic [7:0] dat);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        dat = reg_rdata;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string w);
        rd(a, v);
        cmp_byte(w, e, v);
    endtask
    task automatic check_resets;
        for (int a = 0; a < 16; a++) begin
            rd_chk(a[3:0], rst_val(a), "reset value");
        end
    endtask
    // duty rewritten while the selected timer is stopped, so it must wait for rollover
    task automatic cfg(input int tm, input int pr, input int du, input int pc);
        wr(`A_PINDIR, 8'h01);
        wr(4'h7 + tm[3:0], 8'h00);
        wr(4'hA + tm[3:0], 8'h00);
        wr(`A_TSEL, tm[7:0]);
        wr(4'h4 + tm[3:0], pr[7:0]);
        wr(`A_CTRL, {2'b00, du[1:0], 4'hC});
        wr(`A_DUTY_MSB, du[9:2]);
        wr(`A_FLAGS, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(4'h7 + k[3:0], {5'h00, 1'b1, pc[1:0]});
        end
        v = 8'h00;
        for (int k = 0; k < 1000 && v[tm] !== 1'b1; k++) begin
            rd(`A_FLAGS, v);
        end
        cmp_len("match flag", 1, int'(v[tm]));
        wr(`A_PINDIR, 8'h00);
    endtask
    task automatic pad_hold(input logic lvl);
        repeat (40) @(posedge clk);
        repeat (16) begin
            @(negedge clk);
            cmp_byte("pin level", {7'h00, lvl}, {7'h00, pad});
        end
    endtask
////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_resets;
        // every timer and prescale, random period and in-range duty
        for (t = 0; t < 3; t++) begin
            for (ps = 0; ps < 3; ps++) begin
                p = 1 + $unsigned($random(seed)) % 6;
                d = 1 + $unsigned($random(seed)) % (4 * p + 3);
                cfg(t, p, d, ps);
                repeat (12 * (p + 1) * psf(ps) + 20) @(posedge clk);
                cmp_len("period", 4 * (p + 1) * psf(ps), per_len);
                cmp_len("high time", d * psf(ps), hi_len);
                rd_chk(`A_DUTY_SHADOW, d[9:2], "shadow");
                wr(`A_DUTY_SHADOW, ~d[9:2]);
                rd_chk(`A_DUTY_SHADOW, d[9:2], "shadow kept");
            end
        end
        // sleep freezes the count; zero duty never raises the pin
        cfg(0, 3, 0, 0);
        @(posedge clk);
        sleep_req <= 1'b1;
        rd(`A_TCOUNT0, v);
        p = v;
        repeat (37) @(posedge clk);
        rd_chk(`A_TCOUNT0, p[7:0], "frozen count");
        @(posedge clk);
        sleep_req <= 1'b0;
        pad_hold(1'b0);
        cfg(0, 3, 1023, 0);
        pad_hold(1'b1);
        wr(`A_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp_byte("pin enable", 8'h00, {7'h00, pin_oe});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_resets;
        end_of_test;
    end
    // watchdog well beyond the expected run length
    initial begin
        #400000;
        n_mismatch++;
        end_of_test;
    end
endmodule // standard_pwm_channel_tb_top
